// ### rtl/adcc_top.sv
`timescale 1ns/10ps

// Notes on behaviour
// - Start bit written low, high, low begins a conversion on the final fall.
// - Busy is high during conversion, low at completion with result valid.
// - Result is twelve bits; full scale gives all ones.
// - One step is reference over 4096; input equals code times step.
// - Power enable low switches converter off; no conversion runs.
// - Two-bit reference select picks reference; full scale equals it.
// - Format bit arranges twelve result bits across high and low bytes.
// - Transitions above zero sit half a step low; last 1.5 below reference.
// - Conversion is 4 sample plus 12 decision converter clocks, busy throughout.
// - Converter clock is system clock divided by 2**sel, 1 to 128.
// - Completion sets the conversion flag; enabled, it raises the interrupt.

`include "adcc_defs.svh"

module adcc_top #(
    parameter int SAMPLE_CYCLES = `ADCC_SAMPLE_CYC,
    parameter int DIV_SEL_W = `ADCC_DIV_SEL_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comp_in,
    output adcc_pkg::adcc_ana_s ana,
    output logic irq
);
    import adcc_pkg::*;

    localparam int RB = `ADCC_RES_BITS;

    // Counter widths below are four bits
    if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 15 || DIV_SEL_W != `ADCC_DIV_SEL_W) begin : g_bad_param
        $error("adcc_top: unsupported SAMPLE_CYCLES or DIV_SEL_W");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] aw_addr, next_aw_addr;
    logic aw_hold, next_aw_hold;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic w_hold, next_w_hold;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_fire, rd_fire, wr_hit, rd_hit;
    logic [31:0] wmask, wr_old, wr_val, rd_img;
    logic [31:0] img_a, img_b, img_hi, img_lo, img_stat, img_mask, img_en;

    adcc_ctrl_s cfg, next_cfg;
    logic [DIV_SEL_W-1:0] div_sel, next_div_sel;
    logic [1:0] ref_sel, next_ref_sel;
    logic irq_mask, next_irq_mask;
    logic irq_glb, next_irq_glb;
    logic irq_mf, next_irq_mf;

    adcc_state_e state, next_state;
    logic [3:0] samp_cnt, next_samp_cnt;
    logic [3:0] bit_idx, next_bit_idx;
    logic [RB-1:0] trial, next_trial;
    logic [RB-1:0] decided;
    logic [RB-1:0] result, next_result;
    logic busy, next_busy;
    logic start_prev, next_start_prev;
    logic irq_stat, next_irq_stat;
    logic next_irq;
    adcc_ana_s next_ana;
    logic go, done, tick, stat_clr;

    ////////////////////////////////////////////////////////////////////////////////
    // Register images and address decode

    // Readback images; unused bits read as zero
    always_comb begin
        img_a = 32'h0000_0000;
        img_a[`ADCC_A_START] = cfg.start;
        img_a[`ADCC_A_BUSY] = busy;
        img_a[`ADCC_A_PWR] = cfg.pwr;
        img_a[`ADCC_A_FMT] = cfg.fmt;
        img_a[`ADCC_A_CHAN_LSB +: 4] = cfg.chan;
        img_a[`ADCC_A_SRC_LSB +: 3] = cfg.src;
        img_b = 32'h0000_0000;
        img_b[`ADCC_B_DIV_LSB +: DIV_SEL_W] = div_sel;
        img_b[`ADCC_B_REF_LSB +: 2] = ref_sel;
        img_hi = 32'h0000_0000;
        img_lo = 32'h0000_0000;
        // Left aligned or right aligned result bytes
        if (!cfg.fmt) begin
            img_hi[7:0] = result[11:4];
            img_lo[7:0] = {result[3:0], 4'h0};
        end else begin
            img_hi[7:0] = {4'h0, result[11:8]};
            img_lo[7:0] = result[7:0];
        end
        img_stat = 32'h0000_0000;
        img_stat[`ADCC_IRQ_DONE] = irq_stat;
        img_mask = 32'h0000_0000;
        img_mask[`ADCC_IRQ_DONE] = irq_mask;
        img_en = 32'h0000_0000;
        img_en[`ADCC_IRQ_GLB] = irq_glb;
        img_en[`ADCC_IRQ_MF] = irq_mf;
    end

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_img = 32'h0000_0000;
        if (s_axi_araddr == `ADCC_OFF_CTRL_A) begin
            rd_img = img_a;
        end else if (s_axi_araddr == `ADCC_OFF_CTRL_B) begin
            rd_img = img_b;
        end else if (s_axi_araddr == `ADCC_OFF_RES_HI) begin
            rd_img = img_hi;
        end else if (s_axi_araddr == `ADCC_OFF_RES_LO) begin
            rd_img = img_lo;
        end else if (s_axi_araddr == `ADCC_OFF_IRQ_STAT) begin
            rd_img = img_stat;
        end else if (s_axi_araddr == `ADCC_OFF_IRQ_MASK) begin
            rd_img = img_mask;
        end else if (s_axi_araddr == `ADCC_OFF_IRQ_EN) begin
            rd_img = img_en;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Write decode; old image lets byte strobes keep untouched lanes
    always_comb begin
        wr_hit = 1'b1;
        wr_old = 32'h0000_0000;
        if (aw_addr == `ADCC_OFF_CTRL_A) begin
            wr_old = img_a;
        end else if (aw_addr == `ADCC_OFF_CTRL_B) begin
            wr_old = img_b;
        end else if (aw_addr == `ADCC_OFF_RES_HI || aw_addr == `ADCC_OFF_RES_LO) begin
            wr_old = 32'h0000_0000;
        end else if (aw_addr == `ADCC_OFF_IRQ_STAT) begin
            wr_old = img_stat;
        end else if (aw_addr == `ADCC_OFF_IRQ_MASK) begin
            wr_old = img_mask;
        end else if (aw_addr == `ADCC_OFF_IRQ_EN) begin
            wr_old = img_en;
        end else begin
            wr_hit = 1'b0;
        end
    end

    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wr_val = (wr_old & ~wmask) | (w_data & wmask);
    assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes

    // Address and data are held separately, so either may come first
    always_comb begin
        next_aw_hold = aw_hold;
        next_aw_addr = aw_addr;
        next_w_hold = w_hold;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rdata = rd_img;
            next_rresp = rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // Ready stays low while a response waits: one transfer at a time
        next_awready = !next_aw_hold && !next_bvalid;
        next_wready = !next_w_hold && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_hold <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADCC_RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold <= next_w_hold;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Busy, result and status are read only; writes to them are dropped
    always_comb begin
        next_cfg = cfg;
        next_div_sel = div_sel;
        next_ref_sel = ref_sel;
        next_irq_mask = irq_mask;
        next_irq_glb = irq_glb;
        next_irq_mf = irq_mf;
        if (wr_fire && aw_addr == `ADCC_OFF_CTRL_A) begin
            next_cfg.start = wr_val[`ADCC_A_START];
            next_cfg.pwr = wr_val[`ADCC_A_PWR];
            next_cfg.fmt = wr_val[`ADCC_A_FMT];
            next_cfg.chan = wr_val[`ADCC_A_CHAN_LSB +: 4];
            next_cfg.src = wr_val[`ADCC_A_SRC_LSB +: 3];
        end else if (wr_fire && aw_addr == `ADCC_OFF_CTRL_B) begin
            next_div_sel = wr_val[`ADCC_B_DIV_LSB +: DIV_SEL_W];
            next_ref_sel = wr_val[`ADCC_B_REF_LSB +: 2];
        end else if (wr_fire && aw_addr == `ADCC_OFF_IRQ_MASK) begin
            next_irq_mask = wr_val[`ADCC_IRQ_DONE];
        end else if (wr_fire && aw_addr == `ADCC_OFF_IRQ_EN) begin
            next_irq_glb = wr_val[`ADCC_IRQ_GLB];
            next_irq_mf = wr_val[`ADCC_IRQ_MF];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= '{src: `ADCC_SRC_RST, chan: `ADCC_CHAN_RST, fmt: 1'b0, pwr: 1'b0, start: 1'b0};
            div_sel <= `ADCC_DIV_RST;
            ref_sel <= `ADCC_REF_RST;
            irq_mask <= 1'b0;
            irq_glb <= 1'b0;
            irq_mf <= 1'b0;
        end else begin
            cfg <= next_cfg;
            div_sel <= next_div_sel;
            ref_sel <= next_ref_sel;
            irq_mask <= next_irq_mask;
            irq_glb <= next_irq_glb;
            irq_mf <= next_irq_mf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter clock and conversion sequencer

    // Falling start after a high phase starts; high start holds the sequencer reset
    assign go = start_prev && !cfg.start && cfg.pwr;

    adcc_clkdiv #(
        .SEL_W(DIV_SEL_W)
    ) u_clkdiv (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(state != ADCC_IDLE),
        .restart(go),
        .sel(div_sel),
        .tick(tick)
    );

    // Keep the bit under test if the comparator says input is at or above trial
    always_comb begin
        decided = trial;
        if (!comp_in) begin
            decided[bit_idx] = 1'b0;
        end
    end

    // Successive approximation, MSB first, one decision per converter clock
    always_comb begin
        next_state = state;
        next_samp_cnt = samp_cnt;
        next_bit_idx = bit_idx;
        next_trial = trial;
        next_result = result;
        done = 1'b0;
        case (state)
            ADCC_IDLE: begin
                if (go) begin
                    next_state = ADCC_SAMPLE;
                    next_samp_cnt = 4'h0;
                end
            end
            ADCC_SAMPLE: begin
                if (tick) begin
                    if (samp_cnt == 4'(SAMPLE_CYCLES - 1)) begin
                        next_state = ADCC_CONVERT;
                        next_bit_idx = 4'(RB - 1);
                        next_trial = {1'b1, {(RB - 1){1'b0}}};
                    end else begin
                        next_samp_cnt = samp_cnt + 4'h1;
                    end
                end
            end
            ADCC_CONVERT: begin
                if (tick) begin
                    if (bit_idx == 4'h0) begin
                        next_state = ADCC_IDLE;
                        next_result = decided;
                        next_trial = '0;
                        done = 1'b1;
                    end else begin
                        next_bit_idx = bit_idx - 4'h1;
                        next_trial = decided;
                        next_trial[bit_idx - 4'h1] = 1'b1;
                    end
                end
            end
            default: begin
                next_state = ADCC_IDLE;
            end
        endcase
        // Start high or power off abandons a conversion without a flag; a final decision in that same cycle still loads result
        if (cfg.start || !cfg.pwr) begin
            next_state = ADCC_IDLE;
            next_trial = '0;
            done = 1'b0;
        end
    end

    // Busy, flag, interrupt and analog drive, all registered
    always_comb begin
        next_start_prev = cfg.start;
        next_busy = (next_state != ADCC_IDLE);
        stat_clr = rd_fire && (s_axi_araddr == `ADCC_OFF_IRQ_STAT);
        // A completion in the clearing cycle wins over the read
        next_irq_stat = (irq_stat && !stat_clr) || done;
        // All three enables must be set; a pending flag raises the interrupt whenever they are
        next_irq = next_irq_stat && irq_mask && irq_glb && irq_mf;
        // Unpowered core sees all zeros so it cannot draw current
        next_ana.pwr = cfg.pwr;
        next_ana.sample = cfg.pwr && (next_state == ADCC_SAMPLE);
        next_ana.src = cfg.pwr ? cfg.src : 3'h0;
        next_ana.chan = cfg.pwr ? cfg.chan : 4'h0;
        next_ana.ref_sel = cfg.pwr ? ref_sel : 2'h0;
        // Trial code; the core places each threshold half a step low
        next_ana.trial = cfg.pwr ? next_trial : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ADCC_IDLE;
            samp_cnt <= 4'h0;
            bit_idx <= 4'h0;
            trial <= '0;
            result <= `ADCC_RES_RST;
            busy <= 1'b0;
            start_prev <= 1'b0;
            irq_stat <= 1'b0;
            irq <= 1'b0;
            ana <= '0;
        end else begin
            state <= next_state;
            samp_cnt <= next_samp_cnt;
            bit_idx <= next_bit_idx;
            trial <= next_trial;
            result <= next_result;
            busy <= next_busy;
            start_prev <= next_start_prev;
            irq_stat <= next_irq_stat;
            irq <= next_irq;
            ana <= next_ana;
        end
    end
endmodule

// ### shared/adcc_defs.svh
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define ADCC_OFF_CTRL_A 8'h00
`define ADCC_OFF_CTRL_B 8'h04
`define ADCC_OFF_RES_HI 8'h08
`define ADCC_OFF_RES_LO 8'h0C
`define ADCC_OFF_IRQ_STAT 8'h10
`define ADCC_OFF_IRQ_MASK 8'h14
`define ADCC_OFF_IRQ_EN 8'h18

// Field positions in converter_control_reg_a
`define ADCC_A_START 0
`define ADCC_A_BUSY 1
`define ADCC_A_PWR 2
`define ADCC_A_FMT 3
`define ADCC_A_CHAN_LSB 4
`define ADCC_A_SRC_LSB 8

// Field positions in converter_control_reg_b
`define ADCC_B_DIV_LSB 0
`define ADCC_B_REF_LSB 4

// Interrupt status and mask layout, and the enable register
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_GLB 0
`define ADCC_IRQ_MF 1

// Reset values
`define ADCC_CHAN_RST 4'h0
`define ADCC_SRC_RST 3'h0
`define ADCC_DIV_RST 3'h0
`define ADCC_REF_RST 2'h0
`define ADCC_RES_RST 12'h000

// Conversion timing in converter clock cycles, result width and divider select width
`define ADCC_SAMPLE_CYC 4
`define ADCC_CONV_CYC 12
`define ADCC_RES_BITS 12
`define ADCC_DIV_SEL_W 3

// AXI responses
`define ADCC_RESP_OKAY 2'b00
`define ADCC_RESP_SLVERR 2'b10

`endif

// ### shared/adcc_pkg.sv
`include "adcc_defs.svh"

package adcc_pkg;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONVERT = 2'b10
    } adcc_state_e;

    // Software control fields of converter_control_reg_a
    typedef struct packed {
        logic [2:0] src;
        logic [3:0] chan;
        logic fmt;
        logic pwr;
        logic start;
    } adcc_ctrl_s;

    // Drive towards the analog multiplexer and converter core
    typedef struct packed {
        logic pwr;
        logic sample;
        logic [2:0] src;
        logic [3:0] chan;
        logic [1:0] ref_sel;
        logic [`ADCC_RES_BITS-1:0] trial;
    } adcc_ana_s;

endpackage

// ### rtl/adcc_clkdiv.sv
`timescale 1ns/10ps

`include "adcc_defs.svh"

module adcc_clkdiv #(
    parameter int SEL_W = `ADCC_DIV_SEL_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic restart,
    input wire logic [SEL_W-1:0] sel,
    output logic tick
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] mask;

    // Low sel bits of the counter all ones marks one period of 2**sel
    for (genvar i = 0; i < CNT_W; i++) begin : g_mask
        assign mask[i] = (i < sel);
    end

    assign tick = run && ((cnt & mask) == mask);

    // Restart aligns the first tick to the start of a conversion
    always_comb begin
        next_cnt = cnt;
        if (restart || !run) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

// ### test/adcc_core_model.sv
`timescale 1ns/10ps

// Ideal comparator in front of the successive approximation logic
module adcc_core_model (
    input wire logic aclk,
    input adcc_pkg::adcc_ana_s ana,
    input wire logic [11:0] level,
    output logic comp_in
);
    import adcc_pkg::*;
    logic flip = 1'b0;

    // Unpowered core gives no valid answer, so the line wanders
    always @(posedge aclk) begin
        flip <= ~flip;
    end

    // Level is already in code steps of reference over 4096
    assign comp_in = ana.pwr ? (level >= ana.trial) : flip;
endmodule

// ### test/adcc_asserts.sv
`timescale 1ns/10ps

module adcc_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input adcc_pkg::adcc_ana_s ana,
    input wire logic irq
);
    import adcc_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////
    // Converter drive
    off_zero_a: assert property (!ana.pwr |-> ana == '0)
        else $error("analog drive not zero while unpowered");

    ////////////////////////////////////////////////////////////////
    // Bus channel timing and holding
    write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    resp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
        else $error("illegal read response code");

    // Main scenarios reached
    cov_irq: cover property ($rose(irq));
    cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cov_sample: cover property ($fell(ana.sample) && ana.pwr);
endmodule

// ### test/adcc_top_tb.sv
`timescale 1ns/10ps

module adcc_top_tb;
    import adcc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic comp_in;
    adcc_ana_s ana;
    logic irq;
    logic [11:0] level = 12'h000;
    logic [31:0] d;
    logic [1:0] r;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    initial forever #20 aclk = ~aclk;

    adcc_top u_adcc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .comp_in, .ana, .irq);
    adcc_core_model u_adcc_core_model (.aclk, .ana, .level, .comp_in);

    ////////////////////////////////////////////////////////////////
    // Verdict and hang guard
    task automatic stop_test;
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Slowest scenario is well under this
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Bus master; each channel released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (aw_ok && w_ok && s_axi_bvalid === 1'b1) break;
            if (s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
        chk("write resp", 32'h0, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(what, exp, d);
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rdchk("ctrl_a", 8'h00, 32'h0);
        rdchk("res_hi", 8'h08, 32'h0);
        rd(8'h40);
        chk("unmapped resp", 32'h2, {30'h0, r});
        chk("unmapped data", 32'h0, d);
    endtask

    // Internal source, masked irq, completion found by polling
    task automatic t_poll;
        level <= 12'hA5C;
        wr(8'h04, 32'h20);
        wr(8'h00, 32'h04);
        wr(8'h00, 32'h34);
        wr(8'h00, 32'h134);
        wr(8'h00, 32'h135);
        wr(8'h00, 32'h134);
        rd(8'h00);
        chk("busy", 32'h1, {31'h0, d[1]});
        chk("ana fields", 32'h1_3_2, {21'h0, ana.src, ana.chan, 2'h0, ana.ref_sel});
        rdchk("res_hi held", 8'h08, 32'h0);
        rd(8'h00);
        for (int i = 0; i < 40 && d[1] !== 1'b0; i++) rd(8'h00);
        chk("busy done", 32'h0, {31'h0, d[1]});
        chk("irq masked", 32'h0, {31'h0, irq});
        rdchk("res_hi", 8'h08, 32'hA5);
        rdchk("res_lo", 8'h0C, 32'hC0);
        rdchk("status", 8'h10, 32'h1);
        rdchk("status cleared", 8'h10, 32'h0);
    endtask

    // Divided clock, full scale, interrupt path
    task automatic t_irq;
        int n;
        n = 0;
        level <= 12'hFFF;
        wr(8'h18, 32'h3);
        wr(8'h14, 32'h1);
        wr(8'h04, 32'h02);
        wr(8'h00, 32'h0D);
        wr(8'h00, 32'h0C);
        while (irq !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        chk("conv cycles", 32'h1, {31'h0, n >= 64 && n <= 66});
        rdchk("res_hi fmt1", 8'h08, 32'h0F);
        rdchk("res_lo fmt1", 8'h0C, 32'hFF);
        rdchk("status", 8'h10, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask

    // Start pulse while unpowered does nothing
    task automatic t_power;
        wr(8'h00, 32'h08);
        wr(8'h00, 32'h09);
        wr(8'h00, 32'h08);
        rd(8'h00);
        chk("busy off", 32'h0, {31'h0, d[1]});
        chk("ana off", 32'h0, {9'h0, ana});
        rdchk("res_lo kept", 8'h0C, 32'hFF);
        rdchk("no flag", 8'h10, 32'h0);
    endtask

    // Reset in mid-conversion drops busy and the old result
    task automatic t_midreset;
        wr(8'h00, 32'h05);
        wr(8'h00, 32'h04);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk("ctrl_a after reset", 8'h00, 32'h0);
        rdchk("res_hi after reset", 8'h08, 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_poll();
        t_irq();
        t_power();
        t_midreset();
        stop_test();
    end
endmodule

bind adcc_top adcc_asserts u_adcc_asserts (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ana, .irq);
